// ==== core/edge_latch.v ====
// Edge detector and interrupt latch for one filtered input.
module edge_latch (
    input  wire aclk,
    input  wire aresetn,
    input  wire level,
    input  wire falling_sel,
    input  wire allow,
    input  wire accept,
    input  wire sw_clear,
    output reg  latch_q
);

    reg  prev_q;
    wire rise;
    wire fall;
    wire set_edge;

    assign rise     = level & ~prev_q;
    assign fall     = ~level & prev_q;
    assign set_edge = allow & (falling_sel ? fall : rise);

    always @(posedge aclk) begin
        if (!aresetn) begin
            prev_q  <= 1'b1;
            latch_q <= 1'b0;
        end else begin
            prev_q  <= level;
            // A new edge wins over an acceptance or a software clear.
            latch_q <= (latch_q & ~accept & ~sw_clear) | set_edge;
        end
    end

endmodule // edge_latch

// ==== core/ext_irq_inputs.v ====
// Five external interrupt inputs with noise filters and AXI4-Lite registers.
//
// Local design decision: the AXI4-Lite interface to the registers.
`include "ext_irq_regs.vh"

module ext_irq_inputs (
    input  wire                 aclk,
    input  wire                 aresetn,
    // AXI4-Lite slave.
    input  wire [`ADDR_W-1:0]   s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output wire                 s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output wire                 s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [`ADDR_W-1:0]   s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output wire                 s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Interrupt pins.
    input  wire                 ext_irq_zero,
    input  wire                 ext_irq_one,
    input  wire                 ext_irq_two,
    input  wire                 ext_irq_three,
    input  wire                 ext_irq_five,
    // System side.
    input  wire                 slow_mode,
    input  wire [4:0]           irq_accept,
    output wire [4:0]           irq_request,
    output reg                  shared_port_pin,
    output wire                 irq
);

    // Register state.
    reg  [7:0]  ext_irq_control_q;
    reg  [5:0]  irq_enable_register_q;
    reg  [4:0]  irq_mask_q;
    reg  [4:0]  latch_clear_q;

    // Write channel holding state.
    reg                 aw_have_q;
    reg  [`ADDR_W-1:0]  aw_addr_q;
    reg                 w_have_q;
    reg  [31:0]         w_data_q;
    reg  [3:0]          w_strb_q;

    // Low-frequency tick.
    reg  [9:0]  fs_count_q;
    reg         fs_tick_q;

    // Full-width copies of the header figures, cut to size where used.
    localparam [31:0] fs_last   = `FS_DIV - 1;
    localparam [31:0] thr_zf    = `THR_ZERO_FIVE;
    localparam [31:0] thr_one_s = `THR_ONE_SHORT;
    localparam [31:0] thr_one_l = `THR_ONE_LONG;
    localparam [31:0] thr_tt    = `THR_TWO_THREE;
    localparam [31:0] thr_slow  = `THR_SLOW;

    wire        irq_one_filter_sel;
    wire        pin_function_sel;
    wire        irq_one_edge_sel;
    wire        irq_two_edge_sel;
    wire        irq_three_edge_sel;
    wire        master_irq_enable;
    wire [4:0]  enable_flags;

    wire [4:0]  pins;
    wire [4:0]  synced;
    wire [4:0]  filtered;
    wire [4:0]  latches;
    wire [4:0]  falling_sel;
    wire [4:0]  allow;
    wire        sample_en;
    wire [7:0]  thr_one_fast;
    reg  [39:0] thresholds;

    wire        do_write;
    wire        byte0_wr;
    reg  [31:0] read_word;
    reg  [1:0]  read_resp;
    reg  [1:0]  write_resp;

    assign irq_one_filter_sel = ext_irq_control_q[`CTL_ONE_FILTER];
    assign pin_function_sel   = ext_irq_control_q[`CTL_PIN_FUNCTION];
    assign irq_one_edge_sel   = ext_irq_control_q[`CTL_ONE_EDGE];
    assign irq_two_edge_sel   = ext_irq_control_q[`CTL_TWO_EDGE];
    assign irq_three_edge_sel = ext_irq_control_q[`CTL_THREE_EDGE];
    assign master_irq_enable  = irq_enable_register_q[`EN_MASTER];
    assign enable_flags       = irq_enable_register_q[5:`EN_FLAGS_LSB];

    assign pins = {ext_irq_five, ext_irq_three, ext_irq_two,
                   ext_irq_one, ext_irq_zero};

    // Slow clock tick: one pulse every low-frequency period.
    always @(posedge aclk) begin
        if (!aresetn) begin
            fs_count_q <= 10'h000;
            fs_tick_q  <= 1'b0;
        end else if (fs_count_q == fs_last[9:0]) begin
            fs_count_q <= 10'h000;
            fs_tick_q  <= 1'b1;
        end else begin
            fs_count_q <= fs_count_q + 10'h001;
            fs_tick_q  <= 1'b0;
        end
    end

    // Normal mode samples every fast cycle, slow modes once per slow period.
    assign sample_en = slow_mode ? fs_tick_q : 1'b1;

    // Window select acts on the next sample, well inside 26 fast periods.
    assign thr_one_fast = irq_one_filter_sel ?
                          thr_one_s[7:0] : thr_one_l[7:0];

    always @* begin
        if (slow_mode) begin
            thresholds = {5{thr_slow[7:0]}};
        end else begin
            thresholds[8*`SRC_ZERO  +: 8] = thr_zf[7:0];
            thresholds[8*`SRC_FIVE  +: 8] = thr_zf[7:0];
            thresholds[8*`SRC_ONE   +: 8] = thr_one_fast;
            thresholds[8*`SRC_TWO   +: 8] = thr_tt[7:0];
            thresholds[8*`SRC_THREE +: 8] = thr_tt[7:0];
        end
    end

    // Zero and five are fixed to falling edges; the others follow control.
    assign falling_sel = {1'b1, irq_three_edge_sel, irq_two_edge_sel,
                          irq_one_edge_sel, 1'b1};

    // The shared pin sets no latch while it serves as a port.
    assign allow = {4'hf, pin_function_sel};

    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_src
            pin_noise_filter u_filter (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .pin       (pins[i]),
                .sample_en (sample_en),
                .threshold (thresholds[8*i +: 8]),
                .synced    (synced[i]),
                .level_q   (filtered[i])
            );
            // Latch is set on the cycle after the filtered edge.
            edge_latch u_latch (
                .aclk        (aclk),
                .aresetn     (aresetn),
                .level       (filtered[i]),
                .falling_sel (falling_sel[i]),
                .allow       (allow[i]),
                .accept      (irq_accept[i]),
                .sw_clear    (latch_clear_q[i]),
                .latch_q     (latches[i])
            );
        end
    endgenerate

    // Shared pin read as a port through the synchroniser.
    always @(posedge aclk) begin
        if (!aresetn) begin
            shared_port_pin <= 1'b1;
        end else begin
            shared_port_pin <= synced[`SRC_ZERO];
        end
    end

    // Requests toward the CPU acceptance logic.
    assign irq_request = latches & enable_flags &
                         {5{master_irq_enable}} &
                         {4'hf, pin_function_sel};

    // Level interrupt for unmasked pending latches.
    assign irq = |(latches & irq_mask_q);

    // AXI4-Lite write path: address and data taken in either order.
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;
    assign byte0_wr      = w_strb_q[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= {`ADDR_W{1'b0}};
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always @* begin
        case (aw_addr_q)
            `BYTE_ADDR(`IDX_CONTROL),
            `BYTE_ADDR(`IDX_ENABLE),
            `BYTE_ADDR(`IDX_STATUS),
            `BYTE_ADDR(`IDX_MASK),
            `BYTE_ADDR(`IDX_LEVEL): write_resp = `RESP_OKAY;
            default:                write_resp = `RESP_SLVERR;
        endcase
    end

    // Register writes; the status register clears where a one is written.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_irq_control_q     <= `CONTROL_RESET;
            irq_enable_register_q <= `ENABLE_RESET;
            irq_mask_q            <= `MASK_RESET;
            latch_clear_q         <= 5'h00;
        end else begin
            latch_clear_q <= 5'h00;
            if (do_write && byte0_wr) begin
                case (aw_addr_q)
                    `BYTE_ADDR(`IDX_CONTROL): begin
                        ext_irq_control_q <= w_data_q[7:0] &
                                             `CTL_WR_MASK;
                    end
                    `BYTE_ADDR(`IDX_ENABLE): begin
                        irq_enable_register_q <= w_data_q[5:0];
                    end
                    `BYTE_ADDR(`IDX_STATUS): begin
                        latch_clear_q <= w_data_q[4:0];
                    end
                    `BYTE_ADDR(`IDX_MASK): begin
                        irq_mask_q <= w_data_q[4:0];
                    end
                    default: begin
                        latch_clear_q <= 5'h00;
                    end
                endcase
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_resp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read path.
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        read_word = 32'h0000_0000;
        read_resp = `RESP_OKAY;
        case (s_axi_araddr)
            `BYTE_ADDR(`IDX_CONTROL): read_word[7:0] = ext_irq_control_q;
            `BYTE_ADDR(`IDX_ENABLE):  read_word[5:0] = irq_enable_register_q;
            `BYTE_ADDR(`IDX_STATUS):  read_word[4:0] = latches;
            `BYTE_ADDR(`IDX_MASK):    read_word[4:0] = irq_mask_q;
            `BYTE_ADDR(`IDX_LEVEL):   read_word[4:0] = filtered;
            default:                  read_resp      = `RESP_SLVERR;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_word;
            s_axi_rresp  <= read_resp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // ext_irq_inputs

// ==== core/ext_irq_regs.vh ====
// Register map, field positions, reset values and timing counts.
`ifndef EXT_IRQ_REGS_VH
`define EXT_IRQ_REGS_VH

// Register indexes; the byte address on the bus is four times the index.
`define IDX_CONTROL        8'h37
`define IDX_ENABLE         8'h40
`define IDX_STATUS         8'h41
`define IDX_MASK           8'h42
`define IDX_LEVEL          8'h43
`define BYTE_ADDR(idx)     {idx, 2'b00}
`define ADDR_W             10

// Control register fields.
`define CTL_ONE_FILTER     7
`define CTL_PIN_FUNCTION   6
`define CTL_THREE_EDGE     3
`define CTL_TWO_EDGE       2
`define CTL_ONE_EDGE       1
`define CTL_WR_MASK        8'hce
`define CONTROL_RESET      8'h00

// Enable register fields: master at bit 0, source flags above it.
`define EN_MASTER          0
`define EN_FLAGS_LSB       1
`define ENABLE_RESET       6'h00
`define MASK_RESET         5'h00

// Source positions in every five-bit vector.
`define SRC_ZERO           0
`define SRC_ONE            1
`define SRC_TWO            2
`define SRC_THREE          3
`define SRC_FIVE           4

// Noise window figures in high-frequency clock periods.
`define REJ_ZERO_FIVE_FC   2
`define ACC_ZERO_FIVE_FC   7
`define REJ_ONE_SHORT_FC   15
`define ACC_ONE_SHORT_FC   49
`define REJ_ONE_LONG_FC    63
`define ACC_ONE_LONG_FC    193
`define REJ_TWO_THREE_FC   7
`define ACC_TWO_THREE_FC   25
// Slow-mode figures in half low-frequency periods (1 and 3.5).
`define REJ_SLOW_HALF_FS   2
`define ACC_SLOW_HALF_FS   7

// Sample counts that switch the filtered level: midway in each window.
`define THR_ZERO_FIVE  ((`REJ_ZERO_FIVE_FC + `ACC_ZERO_FIVE_FC) / 2)
`define THR_ONE_SHORT  ((`REJ_ONE_SHORT_FC + `ACC_ONE_SHORT_FC) / 2)
`define THR_ONE_LONG   ((`REJ_ONE_LONG_FC + `ACC_ONE_LONG_FC) / 2)
`define THR_TWO_THREE  ((`REJ_TWO_THREE_FC + `ACC_TWO_THREE_FC) / 2)
`define THR_SLOW       ((`REJ_SLOW_HALF_FS + `ACC_SLOW_HALF_FS) / 4)

// Low-frequency tick derived from the 25 MHz clock.
`define FC_HZ              25000000
`define FS_HZ              32768
`define FS_DIV             (`FC_HZ / `FS_HZ)

`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ==== core/pin_noise_filter.v ====
// Pin synchroniser and digital noise filter for one interrupt input.
module pin_noise_filter (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       pin,
    input  wire       sample_en,
    input  wire [7:0] threshold,
    output wire       synced,
    output reg        level_q
);

    reg       sync1_q;
    reg       sync2_q;
    reg [7:0] count_q;
    wire [7:0] count_inc;

    assign count_inc = count_q + 8'h01;
    assign synced    = sync2_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    // A new level must be seen on threshold consecutive samples.
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 8'h00;
            level_q <= 1'b1;
        end else if (sample_en) begin
            if (sync2_q == level_q) begin
                count_q <= 8'h00;
            end else if (count_inc >= threshold) begin
                count_q <= 8'h00;
                level_q <= sync2_q;
            end else begin
                count_q <= count_inc;
            end
        end
    end

endmodule // pin_noise_filter

// ==== tb/ext_irq_chk.sv ====
// Bus handshake and request-holding checks for the interrupt input block.
`include "ext_irq_regs.vh"
module ext_irq_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [4:0]  irq_accept,
    input wire [4:0]  irq_request,
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer stuck");
    property p_read_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read late");
    property p_write_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_write_lat: assert property (p_write_lat) else $error("write late");
    property p_busy_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("taken busy");
    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error data set");
    property p_req_hold;
        !(s_axi_awvalid || s_axi_wvalid) &&
        !$past(s_axi_awvalid || s_axi_wvalid) &&
        !$past(s_axi_awvalid || s_axi_wvalid, 2)
        |=> (($past(irq_request) & ~$past(irq_accept)) & ~irq_request) == 5'h00;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request lost");
    c_req: cover property ($rose(irq_request[0]));
    c_irq: cover property ($rose(irq));
    c_err: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule // ext_irq_chk

bind ext_irq_inputs ext_irq_chk chk_u (.*);

// ==== tb/pin_source.sv ====
// Outside signal sources for the five interrupt pins; idle level is high.
module pin_source (
    input  wire        aclk,
    output logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 5'h1f;
    task automatic hold(input int k, input logic lvl, input int n);
        @(posedge aclk);
        pins[k] <= lvl;
        repeat (n) @(posedge aclk);
    endtask
endmodule // pin_source

// ==== tb/testbench.sv ====
// Self-checking bench for the external interrupt input block.
`include "ext_irq_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
        int         k;
        int         len;
    } row_t;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [`ADDR_W-1:0] s_axi_awaddr = 10'h000;
    logic [`ADDR_W-1:0] s_axi_araddr = 10'h000;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic [31:0]       s_axi_wdata = 32'h0;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              slow_mode = 1'b0;
    logic [4:0]        irq_accept = 5'h00;
    wire               s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire               s_axi_arready, s_axi_rvalid, shared_port_pin, irq;
    wire  [1:0]        s_axi_bresp, s_axi_rresp;
    wire  [31:0]       s_axi_rdata;
    wire  [4:0]        irq_request, pins;
    wire               ext_irq_zero = pins[0];
    wire               ext_irq_one = pins[1];
    wire               ext_irq_two = pins[2];
    wire               ext_irq_three = pins[3];
    wire               ext_irq_five = pins[4];
    logic [31:0]       rd_data;
    logic [1:0]        rd_resp;
    logic [1:0]        wr_resp;
    int                num_errors = 0;
    int                compares = 0;
    int                cyc = 0;
    row_t rows[21] = '{
        '{`IDX_CONTROL, 8'hff, 8'hce, 0, 0},
        '{`IDX_CONTROL, 8'h00, 8'h00, 0, 0},
        '{`IDX_ENABLE, 8'hff, 8'h3f, 0, 0},
        '{`IDX_ENABLE, 8'h00, 8'h00, 0, 0},
        '{`IDX_MASK, 8'hff, 8'h1f, 0, 0},
        '{`IDX_MASK, 8'h00, 8'h00, 0, 0},
        '{`IDX_LEVEL, 8'h00, 8'h1f, 0, 0},
        '{8'h50, 8'hff, 8'h00, 0, 0},
        '{8'h00, 8'h00, 8'h00, 0, 7},
        '{8'h00, 8'h40, 8'h00, 0, 1},
        '{8'h00, 8'h40, 8'h01, 0, 7},
        '{8'h00, 8'h00, 8'h00, 4, 1},
        '{8'h00, 8'h00, 8'h10, 4, 7},
        '{8'h00, 8'h82, 8'h00, 1, 14},
        '{8'h00, 8'h82, 8'h02, 1, 49},
        '{8'h00, 8'h02, 8'h00, 1, 62},
        '{8'h00, 8'h02, 8'h02, 1, 193},
        '{8'h00, 8'h04, 8'h00, 2, 6},
        '{8'h00, 8'h04, 8'h04, 2, 25},
        '{8'h00, 8'h08, 8'h00, 3, 6},
        '{8'h00, 8'h08, 8'h08, 3, 25}
    };

    ext_irq_inputs dut_u (.*);
    pin_source src_u (.aclk(aclk), .pins(pins));

    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= `BYTE_ADDR(idx);
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge aclk);
        s_axi_araddr  <= `BYTE_ADDR(idx);
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].len == 0) begin
                wr(rows[i].idx, rows[i].wd);
                rd(rows[i].idx);
                chk(rd_resp, rows[i].idx == 8'h50 ? `RESP_SLVERR : `RESP_OKAY);
                chk(rd_data, rows[i].exp);
                chk(wr_resp, rows[i].idx == 8'h50 ? `RESP_SLVERR : `RESP_OKAY);
            end else begin
                wr(`IDX_CONTROL, rows[i].wd);
                wr(`IDX_STATUS, 8'h1f);
                src_u.hold(rows[i].k, 1'b0, rows[i].len);
                src_u.hold(rows[i].k, 1'b1, 300);
                rd(`IDX_STATUS);
                chk(rd_data, rows[i].exp);
            end
        end
        // Each selectable edge: falling must latch while low, rising after.
        for (int k = 1; k < 4; k++) begin
            for (int s = 0; s < 2; s++) begin
                wr(`IDX_CONTROL, 8'h80 | 8'(s << k));
                wr(`IDX_STATUS, 8'h1f);
                src_u.hold(k, 1'b0, 60);
                rd(`IDX_STATUS);
                chk(rd_data, s ? (1 << k) : 0);
                src_u.hold(k, 1'b1, 60);
                rd(`IDX_STATUS);
                chk(rd_data, 1 << k);
            end
        end
        wr(`IDX_CONTROL, 8'h00);
        src_u.hold(0, 1'b0, 6);
        #1 chk(shared_port_pin, 1'b0);
        src_u.hold(0, 1'b1, 6);
        #1 chk(shared_port_pin, 1'b1);
        wr(`IDX_CONTROL, 8'h40);
        wr(`IDX_STATUS, 8'h1f);
        wr(`IDX_ENABLE, 8'h03);
        src_u.hold(0, 1'b0, 10);
        src_u.hold(0, 1'b1, 30);
        #1 chk(irq_request, 5'h01);
        chk(irq, 1'b0);
        wr(`IDX_MASK, 8'h01);
        #1 chk(irq, 1'b1);
        wr(`IDX_ENABLE, 8'h02);
        #1 chk(irq_request, 5'h00);
        wr(`IDX_ENABLE, 8'h03);
        wr(`IDX_CONTROL, 8'h00);
        #1 chk(irq_request, 5'h00);
        wr(`IDX_CONTROL, 8'h40);
        repeat (20) @(posedge aclk);
        #1 chk(irq_request, 5'h01);
        @(posedge aclk) irq_accept <= 5'h01;
        @(posedge aclk) irq_accept <= 5'h00;
        @(posedge aclk);
        #1 chk(irq_request, 5'h00);
        chk(irq, 1'b0);
        wr(`IDX_MASK, 8'h10);
        src_u.hold(4, 1'b0, 10);
        src_u.hold(4, 1'b1, 30);
        wr(`IDX_STATUS, 8'h01);
        rd(`IDX_STATUS);
        chk(rd_data, 32'h10);
        #1 chk(irq, 1'b1);
        wr(`IDX_STATUS, 8'h10);
        rd(`IDX_STATUS);
        chk(rd_data, 32'h0);
        #1 chk(irq, 1'b0);
        @(posedge aclk) slow_mode <= 1'b1;
        src_u.hold(4, 1'b0, 700);
        src_u.hold(4, 1'b1, 2000);
        rd(`IDX_STATUS);
        chk(rd_data, 32'h0);
        src_u.hold(4, 1'b0, 2700);
        rd(`IDX_STATUS);
        chk(rd_data, 32'h10);
        src_u.hold(4, 1'b1, 2000);
        @(posedge aclk) slow_mode <= 1'b0;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1 chk(irq_request, 5'h00);
        chk(shared_port_pin, 1'b1);
        rd(`IDX_CONTROL);
        chk(rd_data, 32'h0);
        // A write without byte lane zero must leave the register alone.
        @(posedge aclk) s_axi_wstrb <= 4'he;
        wr(`IDX_CONTROL, 8'h80);
        rd(`IDX_CONTROL);
        chk(rd_data, 32'h0);
        end_sim();
    end
endmodule // testbench
